// file: hdl/ccc_pkg.sv
package ccc_pkg;
  localparam int unsigned NUM_CH = 7;
  localparam int unsigned CNT_W = 16;
  // byte addresses of the register window
  localparam logic [11:0] OFF_CTL0 = 12'h002;
  localparam logic [11:0] OFF_CCR0 = 12'h012;
  localparam logic [11:0] OFF_IV = 12'h01e;
  localparam logic [11:0] ADDR_CTL_BASE = 12'h000;
  localparam logic [11:0] ADDR_CCR_BASE = 12'h040;
  localparam logic [11:0] ADDR_IV = 12'h080;
  localparam logic [11:0] ADDR_TBCTL = 12'h084;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h088;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h08c;
  // control word fields
  localparam int unsigned F_EDGE = 14;
  localparam int unsigned F_SRC = 12;
  localparam int unsigned F_SYNC = 11;
  localparam int unsigned F_LLD = 9;
  localparam int unsigned F_CAP = 8;
  localparam int unsigned F_MODE = 5;
  localparam int unsigned F_IE = 4;
  localparam int unsigned F_IN = 3;
  localparam int unsigned F_OUT = 2;
  localparam int unsigned F_OV = 1;
  localparam int unsigned F_IFG = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'hfff7;
  // timer control bits held locally
  localparam int unsigned F_TIE = 1;
  localparam int unsigned F_TIFG = 0;
  localparam logic [1:0] LLD_WRITE = 2'h0;
  localparam logic [1:0] LLD_ZERO = 2'h1;
  localparam logic [1:0] LLD_ZERO_OR_P = 2'h2;
  localparam logic [1:0] LLD_MATCH = 2'h3;
  localparam logic [7:0] IV_NONE = 8'h00;
  localparam logic [7:0] IV_OVF = 8'h0e;
  // irq status bits: ch1..6, overflow, overrun
  localparam int unsigned IRQ_W = 8;
  localparam int unsigned IRQ_OVF = 6;
  localparam int unsigned IRQ_COV = 7;
  typedef enum logic [2:0] {
    DM_PIN, DM_SET, DM_TOG_RST, DM_SET_RST, DM_TOG, DM_RST, DM_TOG_SET, DM_RST_SET
  } ccc_mode_e;
  typedef enum logic [1:0] {CNT_STOP, CNT_UP, CNT_CONT, CNT_UPDN} ccc_cnt_e;
endpackage

// file: hdl/ccc_channels.sv
// Behaviour
// - latch load 00 copies on compare write, 01 when counter hits zero
// - load 10: zero in up/continuous; channel0 latch or zero in up/down
// - load 11: latch reloads when counter equals the shadow latch
// - measure mode bit 0 compare, 1 capture
// - drive mode field chooses the output action per match pulse
// - interrupt enable gates the pending channel flag
// - input level bit reads the selected capture input
// - pin level bit shows the output; in mode 0 writes drive it
// - overrun flag set on capture overflow, cleared only by software
// - vector: 00h none, 02h..0Ch channels 1..6, 0Eh overflow lowest
module ccc_channels
  import ccc_pkg::*;
#(
  parameter int unsigned N_CH = NUM_CH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter side
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [1:0] count_mode,
  input wire logic cnt_tick,
  input wire logic cnt_overflow,
  input wire logic [N_CH-1:0] cap_in_a,
  input wire logic [N_CH-1:0] cap_in_b,
  // channel outputs
  output logic [N_CH-1:0] ch_out,
  output logic [N_CH-1:0] match_pulse,
  output logic [N_CH-1:0] channel_irq,
  output logic irq
);
  logic [15:0] ctl_q [N_CH];
  logic [CNT_W-1:0] ccr_q [N_CH];
  logic [CNT_W-1:0] shadow_compare_latch [N_CH];
  logic [15:0] tctl_q;
  logic [IRQ_W-1:0] stat_q, mask_q;
  logic [N_CH-1:0] in_meta_q, in_sync_q, sel_in;
  logic [N_CH-1:0] cap_ev, cov_ev, ccr_wr;
  logic [7:0] vec;
  logic wr, rd, ctl_hit, ccr_hit;
  logic [2:0] idx;

  function automatic logic [2:0] reg_index(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    return off[4:2];
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  // zero wait states: every access is a setup plus one access cycle
  assign pready = 1'b1;
  assign ctl_hit = paddr >= ADDR_CTL_BASE && paddr < ADDR_CTL_BASE + 12'h020
    && reg_index(paddr, ADDR_CTL_BASE) < 3'(N_CH);
  assign ccr_hit = paddr >= ADDR_CCR_BASE && paddr < ADDR_CCR_BASE + 12'h020
    && reg_index(paddr, ADDR_CCR_BASE) < 3'(N_CH);
  assign idx = ctl_hit ? reg_index(paddr, ADDR_CTL_BASE) : reg_index(paddr, ADDR_CCR_BASE);
  assign pslverr = psel && penable && !(ctl_hit || ccr_hit || paddr == ADDR_IV
    || paddr == ADDR_TBCTL || paddr == ADDR_IRQ_STAT || paddr == ADDR_IRQ_MASK);

  // with the sync bit set the second flop feeds edge detection; costs two cycles of capture latency
  // two-flop sync
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      in_meta_q <= '0;
      in_sync_q <= '0;
    end else begin
      in_meta_q <= sel_in;
      in_sync_q <= in_meta_q;
    end
  end

  logic [N_CH-1:0] lvl;
  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      unique case (ctl_q[c][F_SRC+:2])
        2'h0: sel_in[c] = cap_in_a[c];
        2'h1: sel_in[c] = cap_in_b[c];
        2'h2: sel_in[c] = 1'b0;
        default: sel_in[c] = 1'b1;
      endcase
      lvl[c] = ctl_q[c][F_SYNC] ? in_sync_q[c] : sel_in[c];
    end
  end

  logic [N_CH-1:0] lvl_prev_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lvl_prev_q <= '0;
    end else begin
      lvl_prev_q <= lvl;
    end
  end

  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      unique case (ctl_q[c][F_EDGE+:2])
        2'h0: cap_ev[c] = 1'b0;
        2'h1: cap_ev[c] = lvl[c] && !lvl_prev_q[c];
        2'h2: cap_ev[c] = !lvl[c] && lvl_prev_q[c];
        default: cap_ev[c] = lvl[c] != lvl_prev_q[c];
      endcase
      cap_ev[c] = cap_ev[c] && ctl_q[c][F_CAP];
      // capture while flag pending is an overrun
      cov_ev[c] = cap_ev[c] && ctl_q[c][F_IFG];
      match_pulse[c] = !ctl_q[c][F_CAP] && cnt_tick
        && counter_value == shadow_compare_latch[c];
      ccr_wr[c] = wr && ccr_hit && idx == 3'(c);
    end
  end

  logic at_zero;
  assign at_zero = cnt_tick && counter_value == '0;

  // compare registers and shadow latches
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int c = 0; c < N_CH; c++) begin
        ccr_q[c] <= '0;
        shadow_compare_latch[c] <= '0;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (ccr_wr[c]) begin
          ccr_q[c] <= pwdata[CNT_W-1:0];
        end else if (cap_ev[c]) begin
          ccr_q[c] <= counter_value;
        end
        unique case (ctl_q[c][F_LLD+:2])
          LLD_WRITE: if (ccr_wr[c]) shadow_compare_latch[c] <= pwdata[CNT_W-1:0];
          LLD_ZERO: if (at_zero) shadow_compare_latch[c] <= ccr_q[c];
          LLD_ZERO_OR_P: begin
            if (at_zero || (count_mode == CNT_UPDN && cnt_tick
                && counter_value == shadow_compare_latch[0])) begin
              shadow_compare_latch[c] <= ccr_q[c];
            end
          end
          default: if (cnt_tick && counter_value == shadow_compare_latch[c]) begin
            shadow_compare_latch[c] <= ccr_q[c];
          end
        endcase
      end
    end
  end

  // control words, output drive, flags
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int c = 0; c < N_CH; c++) begin
        ctl_q[c] <= CTL_RESET;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (wr && ctl_hit && idx == 3'(c)) begin
          ctl_q[c] <= (pwdata[15:0] & CTL_WMASK) | (ctl_q[c] & ~CTL_WMASK);
        end
        // drive mode on match pulse; modes 2, 3, 6 and 7 use channel0 match for the second action
        if (match_pulse[c] || (c != 0 && match_pulse[0])) begin
          unique case (ccc_mode_e'(ctl_q[c][F_MODE+:3]))
            DM_PIN: ;
            DM_SET: if (match_pulse[c]) ctl_q[c][F_OUT] <= 1'b1;
            DM_TOG_RST: ctl_q[c][F_OUT] <= match_pulse[c] ? !ctl_q[c][F_OUT] : 1'b0;
            DM_SET_RST: ctl_q[c][F_OUT] <= match_pulse[c] ? 1'b1 : 1'b0;
            DM_TOG: if (match_pulse[c]) ctl_q[c][F_OUT] <= !ctl_q[c][F_OUT];
            DM_RST: if (match_pulse[c]) ctl_q[c][F_OUT] <= 1'b0;
            DM_TOG_SET: ctl_q[c][F_OUT] <= match_pulse[c] ? !ctl_q[c][F_OUT] : 1'b1;
            DM_RST_SET: ctl_q[c][F_OUT] <= match_pulse[c] ? 1'b0 : 1'b1;
          endcase
        end
        // overrun set wins over the software clear
        if (cov_ev[c]) ctl_q[c][F_OV] <= 1'b1;
        // flag set wins over the clear
        if (cap_ev[c] || match_pulse[c]) ctl_q[c][F_IFG] <= 1'b1;
        ctl_q[c][F_IN] <= lvl[c];
      end
    end
  end

  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      ch_out[c] = ctl_q[c][F_OUT];
      channel_irq[c] = ctl_q[c][F_IE] && ctl_q[c][F_IFG];
    end
  end

  // timer overflow flag and enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tctl_q <= '0;
    end else begin
      if (wr && paddr == ADDR_TBCTL) begin
        tctl_q <= {14'h0000, pwdata[F_TIE], pwdata[F_TIFG]};
      end
      if (cnt_overflow) tctl_q[F_TIFG] <= 1'b1;
    end
  end

  always_comb begin
    vec = IV_NONE;
    if (tctl_q[F_TIE] && tctl_q[F_TIFG]) vec = IV_OVF;
    for (int c = N_CH - 1; c >= 1; c--) begin
      if (channel_irq[c]) vec = 8'(2 * c);
    end
  end

  // sticky irq status, write one to clear
  logic [IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    for (int c = 1; c < N_CH && c <= 6; c++) begin
      ev[c-1] = cap_ev[c] || match_pulse[c];
    end
    ev[IRQ_OVF] = cnt_overflow;
    ev[IRQ_COV] = |cov_ev;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr && paddr == ADDR_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | ev;
      if (wr && paddr == ADDR_IRQ_MASK) mask_q <= pwdata[IRQ_W-1:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  // read data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (rd && !penable) begin
      prdata <= '0;
      if (ctl_hit) prdata <= {16'h0000, ctl_q[idx]};
      else if (ccr_hit) prdata <= {16'h0000, ccr_q[idx]};
      else if (paddr == ADDR_IV) prdata <= {24'h00_0000, vec};
      else if (paddr == ADDR_TBCTL) prdata <= {16'h0000, tctl_q};
      else if (paddr == ADDR_IRQ_STAT) prdata <= {24'h00_0000, stat_q};
      else if (paddr == ADDR_IRQ_MASK) prdata <= {24'h00_0000, mask_q};
    end
  end

  a_vec_none: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(|channel_irq[N_CH-1:1]) && !(tctl_q[F_TIE] && tctl_q[F_TIFG]) |-> vec == IV_NONE)
    else $error("vector not zero when idle");
  a_vec_ch1: assert property (@(posedge clk_sys) disable iff (!rstn)
    channel_irq[1] |-> vec == 8'h02)
    else $error("channel 1 not top priority");
  a_vec_ovf: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(|channel_irq[N_CH-1:1]) && tctl_q[F_TIE] && tctl_q[F_TIFG] |-> vec == IV_OVF)
    else $error("overflow vector missing");
  a_ov_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[4][F_OV] && !(wr && ctl_hit && idx == 3'h4) |=> ctl_q[4][F_OV])
    else $error("overrun dropped by hardware");
  a_ov_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    cov_ev[4] |=> ctl_q[4][F_OV])
    else $error("overrun not set");
  a_no_cap_cmp: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ctl_q[1][F_CAP] |-> !cap_ev[1])
    else $error("capture in compare mode");
  a_cap_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    cap_ev[4] && !ccr_wr[4] |=> ccr_q[4] == $past(counter_value))
    else $error("capture did not store the count");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    channel_irq[2] |-> ctl_q[2][F_IE] && ctl_q[2][F_IFG])
    else $error("irq not gated");
  a_ifg_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    match_pulse[2] |=> ctl_q[2][F_IFG])
    else $error("match did not raise the flag");
  a_ifg_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[4][F_IFG] && !(wr && ctl_hit && idx == 3'h4) |=> ctl_q[4][F_IFG])
    else $error("flag dropped without a write");
  a_in_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> ctl_q[5][F_IN] == $past(lvl[5]))
    else $error("input level bit stale");
  a_out_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    ch_out[1] == ctl_q[1][F_OUT])
    else $error("output differs from pin bit");
  a_lld_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    ccr_wr[1] && ctl_q[1][F_LLD+:2] == LLD_WRITE |=>
    shadow_compare_latch[1] == $past(pwdata[CNT_W-1:0]))
    else $error("latch not loaded on write");
  a_lld_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[2][F_LLD+:2] == LLD_ZERO && at_zero |=>
    shadow_compare_latch[2] == $past(ccr_q[2]))
    else $error("latch not loaded at zero");
  a_lld_updn: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[2][F_LLD+:2] == LLD_ZERO_OR_P && count_mode == CNT_UPDN && cnt_tick
    && counter_value == shadow_compare_latch[0] |=>
    shadow_compare_latch[2] == $past(ccr_q[2]))
    else $error("latch not loaded at channel0 latch");
  a_lld_match: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[2][F_LLD+:2] == LLD_MATCH && cnt_tick && counter_value == shadow_compare_latch[2]
    |=> shadow_compare_latch[2] == $past(ccr_q[2]))
    else $error("latch not loaded on own match");
  a_set_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
    match_pulse[1] && ctl_q[1][F_MODE+:3] == DM_SET && !(wr && ctl_hit) |=> ch_out[1])
    else $error("set mode did not set");
  a_tog_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
    match_pulse[1] && ctl_q[1][F_MODE+:3] == DM_TOG && !(wr && ctl_hit) |=>
    ch_out[1] != $past(ch_out[1]))
    else $error("toggle mode did not toggle");
  a_edge_none: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[4][F_EDGE+:2] == 2'h0 |-> !cap_ev[4])
    else $error("capture with edges disabled");
  a_edge_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl_q[4][F_CAP] && ctl_q[4][F_EDGE+:2] == 2'h2 && lvl[4] |-> !cap_ev[4])
    else $error("falling mode captured a high level");
  a_stat_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    stat_q[IRQ_OVF] && !(wr && paddr == ADDR_IRQ_STAT && pwdata[IRQ_OVF]) |=> stat_q[IRQ_OVF])
    else $error("status bit dropped without clear");

  // pin rises, then the channel stays armed for the synchronised path with no rewrite
  sequence s_pin_rise4;
    !sel_in[4] ##1 sel_in[4];
  endsequence
  sequence s_rise_armed4;
    ctl_q[4][F_SYNC] && ctl_q[4][F_CAP] && ctl_q[4][F_EDGE+:2] == 2'h1 && !(wr && ctl_hit);
  endsequence
  a_sync_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_pin_rise4 ##1 s_rise_armed4 |=> cap_ev[4])
    else $error("synchronised rising edge not captured");
endmodule

// file: testbench/ccc_testbench.sv
module testbench
  import ccc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic cnt_tick = 0, cnt_overflow = 0, pready, pslverr, irq, err, a0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] counter_value = '0, cv;
  logic [1:0] count_mode = 2'h1;
  logic [6:0] cap_in_a = '0, cap_in_b = '0, ch_out, match_pulse, channel_irq, mp;
  integer n_fail = 0, cmp_count = 0, seed = 71614;

  always #4 clk_sys = ~clk_sys;

  ccc_channels dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value), .count_mode(count_mode),
    .cnt_tick(cnt_tick), .cnt_overflow(cnt_overflow), .cap_in_a(cap_in_a),
    .cap_in_b(cap_in_b), .ch_out(ch_out), .match_pulse(match_pulse),
    .channel_irq(channel_irq), .irq(irq));

  function automatic logic [11:0] ctl(input int n);
    return ADDR_CTL_BASE + 12'(4 * n);
  endfunction

  function automatic logic [11:0] ccr(input int n);
    return ADDR_CCR_BASE + 12'(4 * n);
  endfunction

  // output model: z marks a match of the base channel
  function automatic logic act(input int m, input bit z, input logic c);
    if (z)
      return (m == 2 || m == 3) ? 1'b0 : (m == 6 || m == 7) ? 1'b1 : c;
    return (m == 1 || m == 3) ? 1'b1 : (m == 5 || m == 7) ? 1'b0 : (m == 0) ? c : ~c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // idle edge at the end keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask

  task automatic tick(input logic [15:0] v);
    counter_value <= v;
    cnt_tick <= 1;
    @(negedge clk_sys);
    mp = match_pulse;
    @(posedge clk_sys);
    cnt_tick <= 0;
    @(posedge clk_sys);
  endtask

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    integer m, e, n;
    logic [15:0] b, old;
    logic init, o1, o2;
    repeat (16) @(posedge clk_sys);
    rstn <= 1;
    cap_in_b <= 7'($random(seed));
    @(posedge clk_sys);
    apb(0, ADDR_IV, 0);
    chk(rd, 0, "vector after reset");
    apb(0, 12'h0f0, 0);
    chk({rd[30:0], err}, 1, "unmapped read");
    apb(1, ccr(0), 32'h0000_0100);
    for (m = 1; m < 8; m++) begin
      init = (m >= 5);
      b = 16'h0200 + 16'($random(seed) & 32'h0000_0fff);
      apb(1, ctl(1), 32'(init) << F_OUT);
      chk(32'(ch_out[1]), 32'(init), "pin write");
      apb(1, ctl(1), (32'(m) << F_MODE) | (32'(init) << F_OUT));
      apb(1, ccr(1), 32'(b));
      o1 = act(m, 0, init);
      o2 = act(m, 1, o1);
      tick(b);
      chk(32'(mp[1]), 1, "match after write load");
      chk(32'(ch_out[1]), 32'(o1), "own match action");
      tick(16'h0100);
      chk(32'(ch_out[1]), 32'(o2), "base match action");
      apb(0, ctl(1), 0);
      chk(32'(rd[F_OUT]), 32'(o2), "pin level bit");
    end
    old = 16'h0300;
    apb(1, ccr(2), 32'(old));
    for (m = 1; m < 4; m++) begin
      b = 16'h0400 + 16'(m);
      count_mode <= (m == 2) ? 2'h3 : 2'h1;
      apb(1, ctl(2), 32'(m) << F_LLD);
      apb(1, ccr(2), 32'(b));
      tick(b);
      chk(32'(mp[2]), 0, "latch held");
      tick(m == 3 ? old : (m == 2 ? 16'h0100 : 16'h0000));
      tick(b);
      chk(32'(mp[2]), 1, "latch loaded");
      old = b;
    end
    apb(1, ADDR_TBCTL, 32'h0000_0002);
    for (n = 1; n < 7; n++)
      apb(1, ctl(n), 32'h0000_0011);
    cnt_overflow <= 1;
    @(posedge clk_sys);
    cnt_overflow <= 0;
    @(posedge clk_sys);
    for (n = 1; n < 8; n++) begin
      apb(0, ADDR_IV, 0);
      chk(rd, 32'(2 * n), "vector priority");
      if (n < 7) begin
        chk(32'(channel_irq[n]), 1, "enabled flag");
        apb(1, ctl(n), 32'h0000_0010);
      end
    end
    apb(1, ctl(3), 32'h0000_0001);
    chk(32'(channel_irq[3]), 0, "flag not enabled");
    apb(1, ctl(3), 0);
    apb(0, ADDR_IRQ_STAT, 0);
    chk(32'(rd[IRQ_OVF]), 1, "overflow event");
    apb(1, ADDR_IRQ_MASK, 0);
    a0 = irq;
    apb(1, ADDR_IRQ_MASK, 32'h0000_00ff);
    chk(32'(irq ^ a0), 1, "mask gates irq");
    apb(1, ADDR_IRQ_STAT, 32'h0000_00ff);
    chk(32'(irq), 0, "status cleared");
    // every input source code: pin a, pin b, tied low, tied high
    for (n = 0; n < 4; n++) begin
      apb(1, ctl(5), 32'(n) << F_SRC);
      apb(0, ctl(5), 0);
      chk(32'(rd[F_IN]), 32'(n == 1 ? cap_in_b[5] : n == 3), "source select");
    end
    // odd edge codes also use the synchronised input path
    for (e = 0; e < 4; e++) begin
      apb(1, ctl(4), (32'(e) << F_EDGE) | (32'(e & 1) << F_SYNC) | 32'h0000_0100);
      cv = 16'($random(seed));
      counter_value <= cv;
      cap_in_a[4] <= 1;
      repeat (6) @(posedge clk_sys);
      apb(0, ctl(4), 0);
      chk(32'(rd[F_IN]), 1, "input high");
      chk(32'(rd[F_IFG]), 32'(e & 1), "rising capture");
      apb(0, ccr(4), 0);
      if (e % 2 == 1)
        chk(rd, 32'(cv), "captured count");
      cap_in_a[4] <= 0;
      repeat (6) @(posedge clk_sys);
      apb(0, ctl(4), 0);
      chk(32'(rd[F_IN]), 0, "input low");
      chk(32'(rd[F_IFG]), 32'(e != 0), "falling capture");
      chk(32'(rd[F_OV]), 32'(e == 3), "overrun");
    end
    repeat (20) @(posedge clk_sys);
    apb(0, ctl(4), 0);
    chk(32'(rd[F_OV]), 1, "overrun sticky");
    apb(1, ctl(4), 32'h0000_0100);
    apb(0, ctl(4), 0);
    chk(32'(rd[F_OV]), 0, "overrun cleared");
    report_and_stop();
  end
endmodule
